// ### fep_ctrl.sv
// flash ecc fault flags and program flash protection, axi4-lite register slave
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "fep_defs.svh"

module fep_ctrl
    import fep_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              mclk,          // 100 MHz clock
    input  wire logic              reset,         // sync, active high
    input  wire logic              special_mode,  // special single chip mode
    input  wire fep_rdfault_type   rd_fault,      // ecc result of array reads
    input  wire fep_nvload_type    nv_load,       // reset-sequence protection byte
    input  wire fep_opreq_type     op_req,        // program/erase check request
    output logic                   op_done,       // check finished, one cycle
    output logic                   op_reject,     // op refused, with op_done
    output logic                   prot_loaded,   // reset load has happened
    output logic                   single_fault_irq, // interrupt request
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // write address
    input  wire logic              s_axi_awvalid, // write address valid
    output logic                   s_axi_awready, // write address ready
    input  wire logic [31:0]       s_axi_wdata,   // write data
    input  wire logic [3:0]        s_axi_wstrb,   // write strobes
    input  wire logic              s_axi_wvalid,  // write data valid
    output logic                   s_axi_wready,  // write data ready
    output logic [1:0]             s_axi_bresp,   // write response
    output logic                   s_axi_bvalid,  // write response valid
    input  wire logic              s_axi_bready,  // write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
    input  wire logic              s_axi_arvalid, // read address valid
    output logic                   s_axi_arready, // read address ready
    output logic [31:0]            s_axi_rdata,   // read data
    output logic [1:0]             s_axi_rresp,   // read response
    output logic                   s_axi_rvalid,  // read data valid
    input  wire logic              s_axi_rready   // read data ready
);

    fep_state_type st;
    fep_state_type next_st;

    // move table held as a vector, since a bare literal cannot be bit-selected
    localparam logic [63:0] MOVE_TABLE = `FEP_MOVE_TABLE;

    // scenario number is {enable, high disable, low disable}
    function automatic logic [2:0] scenario(input fep_prot_type p);
        scenario = {p.popen, p.hdis, p.ldis};
    endfunction : scenario

    // address protected under the given setting
    function automatic logic addr_protected(input fep_prot_type p, input logic [23:0] a);
        logic [23:0] hsz;
        logic [23:0] lsz;
        logic        in_high;
        logic        in_low;
        hsz     = `FEP_HIGH_UNIT << p.hs;
        lsz     = `FEP_LOW_UNIT << p.ls;
        in_high = !p.hdis && (a > (`FEP_PFLASH_TOP - hsz));
        in_low  = !p.ldis && (a >= `FEP_PFLASH_BASE) && (a < (`FEP_PFLASH_BASE + lsz));
        addr_protected = p.popen ? (in_high || in_low) : !(in_high || in_low);
    endfunction : addr_protected

    logic         wr_commit;
    logic         rd_commit;
    logic         prot_wr;
    logic         move_ok;
    fep_prot_type prot_cand;
    logic         op_hit;

    // register engine, bus slave and protection check
    always_comb begin
        next_st   = st;
        wr_commit = st.aw_ok && st.w_ok && !st.bvalid;
        rd_commit = s_axi_arvalid && st.arready;
        prot_wr   = wr_commit && st.w_lane && st.loaded &&
                    (st.aw_idx == `FEP_IDX_PROGRAM_PROT);
        prot_cand = st.prot;

        // address and data taken independently, in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_ok  = 1'b1;
            next_st.aw_idx = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_ok   = 1'b1;
            next_st.w_data = s_axi_wdata[7:0];
            next_st.w_lane = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // candidate protection value, reserved bit never written
        prot_cand.popen = st.w_data[7];
        prot_cand.hdis  = st.w_data[5];
        prot_cand.ldis  = st.w_data[2];
        // high size locked while range active
        if (st.prot.hdis) begin
            prot_cand.hs = st.w_data[4:3];
        end
        // low size locked while range active
        if (st.prot.ldis) begin
            prot_cand.ls = st.w_data[1:0];
        end
        move_ok = special_mode ||
                  MOVE_TABLE[{scenario(st.prot), scenario(prot_cand)}];

        // fault staging gives the one cycle storage delay
        // stage now, flag next cycle
        next_st.stage_d = rd_fault.valid && (rd_fault.double || rd_fault.busy_invalid);
        next_st.stage_s = rd_fault.valid && (rd_fault.single || rd_fault.busy_invalid) &&
                          !st.ign_sf;

        if (wr_commit) begin
            next_st.aw_ok  = 1'b0;
            next_st.w_ok   = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = `FEP_RESP_OKAY;
            if (st.w_lane) begin
                unique case (st.aw_idx)
                    `FEP_IDX_FLASH_ERROR_STAT: begin
                        if (st.w_data[`FEP_BIT_DOUBLE_FAULT]) begin
                            next_st.double_fault_flag = 1'b0;
                        end
                        if (st.w_data[`FEP_BIT_SINGLE_FAULT]) begin
                            next_st.single_fault_flag = 1'b0;
                        end
                    end
                    `FEP_IDX_FLASH_STATUS: begin
                        if (st.w_data[`FEP_BIT_PROT_VIOLATION]) begin
                            next_st.viol = 1'b0;
                        end
                    end
                    `FEP_IDX_FLASH_CONFIG: begin
                        next_st.irq_en = st.w_data[`FEP_BIT_IRQ_ENABLE];
                        next_st.ign_sf = st.w_data[`FEP_BIT_IGNORE_SINGLE];
                    end
                    `FEP_IDX_PROGRAM_PROT: begin
                        if (prot_wr && move_ok) begin
                            next_st.prot = prot_cand;
                        end
                    end
                    default: begin
                        next_st.bresp = `FEP_RESP_SLVERR;
                    end
                endcase
            end
        end

        // staged faults land here; set wins over a same-cycle clear
        // double fault sets flag
        if (st.stage_d) begin
            next_st.double_fault_flag = 1'b1;
        end
        if (st.stage_s) begin
            next_st.single_fault_flag = 1'b1;
        end

        if (nv_load.valid && !st.loaded) begin
            next_st.loaded = 1'b1;
            next_st.prot   = nv_load.dfault ? fep_prot_type'(`FEP_PROT_FULL)
                                            : fep_prot_type'(nv_load.data);
        end

        // block erase needs whole block open
        op_hit = op_req.erase ? (st.prot.popen ? !(st.prot.hdis && st.prot.ldis) : 1'b1)
                              : addr_protected(st.prot, op_req.addr);
        next_st.op_done   = op_req.valid;
        next_st.op_reject = op_req.valid && (op_hit || !st.loaded);
        if (op_req.valid && (op_hit || !st.loaded)) begin
            next_st.viol = 1'b1;
        end

        // read side; reads have no side effects
        if (s_axi_rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (rd_commit) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = `FEP_RESP_OKAY;
            next_st.rdata  = 8'h00;
            unique case (s_axi_araddr[7:2])
                `FEP_IDX_FLASH_ERROR_STAT: next_st.rdata = {6'h00, st.double_fault_flag, st.single_fault_flag};
                `FEP_IDX_FLASH_STATUS:     next_st.rdata = {3'h0, st.viol, 4'h0};
                `FEP_IDX_FLASH_CONFIG:     next_st.rdata = {6'h00, st.ign_sf, st.irq_en};
                `FEP_IDX_PROGRAM_PROT:     next_st.rdata = st.prot;
                default:                   next_st.rresp = `FEP_RESP_SLVERR;
            endcase
        end

        next_st.irq     = next_st.single_fault_flag && next_st.irq_en;
        // one write and one read outstanding at most
        next_st.awready = !next_st.aw_ok && !next_st.bvalid;
        next_st.wready  = !next_st.w_ok && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;
    end

    // single state register; protection starts fully closed until the load
    always_ff @(posedge mclk) begin
        if (reset) begin
            st         <= '0;
            st.prot    <= fep_prot_type'(`FEP_PROT_FULL);
            st.awready <= 1'b1;
            st.wready  <= 1'b1;
            st.arready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready    = st.awready;
    assign s_axi_wready     = st.wready;
    assign s_axi_bvalid     = st.bvalid;
    assign s_axi_bresp      = st.bresp;
    assign s_axi_arready    = st.arready;
    assign s_axi_rvalid     = st.rvalid;
    assign s_axi_rresp      = st.rresp;
    assign s_axi_rdata      = {24'h000000, st.rdata};
    assign op_done          = st.op_done;
    assign op_reject        = st.op_reject;
    assign prot_loaded      = st.loaded;
    assign single_fault_irq = st.irq;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    dfault_store_a: assert property (
        rd_fault.valid && rd_fault.double |=> ##1 st.double_fault_flag)
        else $error("double fault not stored two edges after read");

    flag_delay_a: assert property (
        $rose(st.double_fault_flag) |->
        $past(st.stage_d) && $past(rd_fault.valid, 2))
        else $error("double flag rose without a read two edges before");

    single_gate_a: assert property (
        rd_fault.valid && rd_fault.single && st.ign_sf && !st.single_fault_flag
        && !st.stage_s |=> ##1 !st.single_fault_flag)
        else $error("single flag set while ignored");

    dclear_a: assert property (
        wr_commit && st.w_lane && st.aw_idx == `FEP_IDX_FLASH_ERROR_STAT &&
        st.w_data[1] && !st.stage_d |=> !st.double_fault_flag)
        else $error("double flag not cleared by write of one");

    sclear_keep_a: assert property (
        wr_commit && st.aw_idx == `FEP_IDX_FLASH_ERROR_STAT && !st.w_data[0] && st.single_fault_flag
        |=> st.single_fault_flag)
        else $error("single flag cleared by write of zero");

    nv_fault_a: assert property (
        nv_load.valid && nv_load.dfault && !st.loaded |=> st.prot == `FEP_PROT_FULL && st.loaded)
        else $error("faulty load did not give full protection");

    bad_move_a: assert property (
        prot_wr && !special_mode && !move_ok && !(nv_load.valid && !st.loaded)
        |=> $stable(st.prot))
        else $error("disallowed protection move took effect");

    hsize_lock_a: assert property (
        prot_wr && !st.prot.hdis |=> st.prot.hs == $past(st.prot.hs))
        else $error("high size changed while range active");

    violation_a: assert property (
        op_req.valid && op_hit |=> op_reject && op_done && st.viol)
        else $error("protected op not rejected with violation flag");

    irq_track_a: assert property (
        st.single_fault_flag && st.irq_en |-> single_fault_irq)
        else $error("interrupt missing while flag and enable set");

    // fault flag store, write and keep behaviour
    dflag_keep_a: assert property (
        wr_commit && st.aw_idx == `FEP_IDX_FLASH_ERROR_STAT && !st.w_data[1] && st.double_fault_flag
        |=> st.double_fault_flag)
        else $error("double flag cleared by write of zero");

    sflag_clear_a: assert property (
        wr_commit && st.w_lane && st.aw_idx == `FEP_IDX_FLASH_ERROR_STAT &&
        st.w_data[0] && !st.stage_s |=> !st.single_fault_flag)
        else $error("single flag not cleared by write of one");

    single_store_a: assert property (
        rd_fault.valid && rd_fault.single && !st.ign_sf |=> ##1 st.single_fault_flag)
        else $error("single fault not stored two edges after read");

    dflag_sticky_a: assert property (
        st.double_fault_flag && !(wr_commit && st.w_lane && st.aw_idx == `FEP_IDX_FLASH_ERROR_STAT &&
        st.w_data[1]) |=> st.double_fault_flag)
        else $error("double flag dropped without a clear");

    // protection register writes, load and read back
    lsize_lock_a: assert property (
        prot_wr && !st.prot.ldis |=> st.prot.ls == $past(st.prot.ls))
        else $error("low size changed while range active");

    free_write_a: assert property (
        prot_wr && special_mode |=> st.prot.popen == $past(st.w_data[7]) &&
        st.prot.hdis == $past(st.w_data[5]) && st.prot.ldis == $past(st.w_data[2]))
        else $error("special mode protection write not taken");

    unprot_keep_a: assert property (
        prot_wr && !special_mode && !st.prot.popen |=> !st.prot.popen)
        else $error("normal mode write left unprotect mode");

    full_stays_a: assert property (
        prot_wr && !special_mode && scenario(st.prot) == 3'h3 |=> scenario(st.prot) == 3'h3)
        else $error("normal mode write reduced full protection");

    nv_take_a: assert property (
        nv_load.valid && !nv_load.dfault && !st.loaded
        |=> st.loaded && st.prot == $past(nv_load.data))
        else $error("clean protection byte not loaded");

    prot_read_a: assert property (
        rd_commit && s_axi_araddr[7:2] == `FEP_IDX_PROGRAM_PROT
        |=> s_axi_rdata[7:0] == $past(st.prot))
        else $error("protection read differs from setting in force");

    // program and erase checks
    op_answer_a: assert property (
        op_req.valid |=> op_done)
        else $error("op check gave no answer");

    early_op_a: assert property (
        op_req.valid && !st.loaded |=> op_reject && st.viol)
        else $error("op before protection load not refused");

    erase_block_a: assert property (
        op_req.valid && op_req.erase && !(st.prot.popen && st.prot.hdis && st.prot.ldis)
        |=> op_reject)
        else $error("block erase allowed with a protected sector");

    no_prot_a: assert property (
        op_req.valid && st.loaded && st.prot.popen && st.prot.hdis && st.prot.ldis
        |=> !op_reject)
        else $error("op refused with protection off");

    full_prot_a: assert property (
        op_req.valid && !st.prot.popen && st.prot.hdis && st.prot.ldis |=> op_reject)
        else $error("op allowed under full protection");

    high_open_a: assert property (
        op_req.valid && !op_req.erase && st.loaded && !st.prot.popen && !st.prot.hdis &&
        st.prot.hs == 2'h3 && op_req.addr >= 24'hffc000 |=> !op_reject)
        else $error("op refused inside open high range");

    high_size_a: assert property (
        op_req.valid && !op_req.erase && st.prot.popen && !st.prot.hdis &&
        st.prot.hs == 2'h0 && op_req.addr >= 24'hfff800 |=> op_reject)
        else $error("op allowed inside protected high range");

    low_open_a: assert property (
        op_req.valid && !op_req.erase && st.loaded && !st.prot.popen && !st.prot.ldis &&
        op_req.addr == `FEP_PFLASH_BASE |=> !op_reject)
        else $error("op refused at base of open low range");

    low_size_a: assert property (
        op_req.valid && !op_req.erase && st.prot.popen && !st.prot.ldis && st.prot.ls == 2'h1
        && op_req.addr >= `FEP_PFLASH_BASE && op_req.addr <= 24'hff87ff |=> op_reject)
        else $error("op allowed inside protected low range");

endmodule : fep_ctrl

// ### fep_ctrl_bench.sv
// self-checking bench for the flash fault flags and program flash protection block
`timescale 1ns/1ps

module fep_ctrl_bench
    import fep_pkg::*;
;
    localparam logic [1:0] OKAY   = 2'h0;
    localparam logic [1:0] SLVERR = 2'h2;
    localparam int         LIMIT  = 5000; // whole run needs well under 2000 cycles

    logic            mclk = 1'b0;
    logic            reset = 1'b1;
    logic            special_mode = 1'b0;
    fep_rdfault_type rd_fault = '0;
    fep_nvload_type  nv_load = '0;
    fep_opreq_type   op_req = '0;
    logic            op_done, op_reject, prot_loaded, single_fault_irq;
    logic [7:0]      awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]     wdata = 32'h0, rdata;
    logic [3:0]      wstrb = 4'h0;
    logic            awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic            arvalid = 1'b0, rready = 1'b0;
    logic            awready, wready, bvalid, arready, rvalid;
    logic [1:0]      bresp, rresp;
    int              n_fail = 0;
    int              n_compared = 0;
    int              cycles = 0;

    fep_ctrl #(.ADDR_W(8)) dut (
        .mclk(mclk), .reset(reset), .special_mode(special_mode), .rd_fault(rd_fault),
        .nv_load(nv_load), .op_req(op_req), .op_done(op_done), .op_reject(op_reject),
        .prot_loaded(prot_loaded), .single_fault_irq(single_fault_irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    // 100 MHz clock
    always #5 mclk = ~mclk;

    // hang guard: counts as a mismatch and closes the run
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t: run did not finish", $time);
            summarize();
        end
    end

    task automatic summarize();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // register-sized values and responses
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // single output flags
    task automatic chk_bit(input string what, input logic got, input logic exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk_bit

    // axi write: both channels offered together, bready held until the answer
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] er = OKAY, input logic [3:0] st = 4'hf);
        bit done;
        done = 0;
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {24'h0, d};
        wstrb   <= st;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!done) begin
            @(posedge mclk);
            if (awvalid && awready === 1'b1)
                awvalid <= 1'b0;
            if (wvalid && wready === 1'b1)
                wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                chk("bresp", {30'h0, bresp}, {30'h0, er});
                bready <= 1'b0;
                done = 1;
            end
        end
        // let the release settle before a following call raises bready again
        @(posedge mclk);
    endtask : wr

    // axi read: rready held until rvalid is sampled, data compared at that edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er = OKAY);
        bit done;
        done = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!done) begin
            @(posedge mclk);
            if (arvalid && arready === 1'b1)
                arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                chk("rdata", rdata, {24'h0, exp});
                chk("rresp", {30'h0, rresp}, {30'h0, er});
                rready <= 1'b0;
                done = 1;
            end
        end
        // let the release settle before a following call raises rready again
        @(posedge mclk);
    endtask : rd

    // program/erase check: answer stands in the cycle after the request edge
    task automatic op(input logic [23:0] addr, input logic erase, input logic rej);
        op_req <= '{valid: 1'b1, erase: erase, addr: addr};
        @(posedge mclk);
        op_req <= '0;
        @(posedge mclk);
        chk_bit("op_done", op_done, 1'b1);
        chk_bit("op_reject", op_reject, rej);
    endtask : op

    // one array read result; the flag is visible from the second edge
    task automatic flt(input logic s, input logic d, input logic b);
        rd_fault <= '{valid: 1'b1, single: s, double: d, busy_invalid: b};
        @(posedge mclk);
        rd_fault <= '0;
        @(posedge mclk);
    endtask : flt

    // reset for 16 cycles, then the reset-sequence protection byte
    task automatic restart(input logic df, input logic [7:0] d, input logic [7:0] exp);
        reset <= 1'b1;
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        rd(8'h20, 8'h7f);
        op(24'hff9000, 1'b0, 1'b1);
        nv_load <= '{valid: 1'b1, dfault: df, data: d};
        @(posedge mclk);
        nv_load <= '0;
        @(posedge mclk);
        chk_bit("prot_loaded", prot_loaded, 1'b1);
        rd(8'h20, exp);
    endtask : restart

    initial begin
        // double fault on the protection byte leaves flash fully protected
        restart(1'b1, 8'h00, 8'h7f);
        rd(8'h18, 8'h10);
        wr(8'h18, 8'h10);
        rd(8'h18, 8'h00);
        // clean load, no protection; enlarge only in normal mode
        restart(1'b0, 8'hff, 8'hff);
        op(24'hff8000, 1'b1, 1'b0);
        wr(8'h20, 8'hc7);
        rd(8'h20, 8'hc7);
        op(24'hfff800, 1'b0, 1'b1);
        op(24'hfff7ff, 1'b0, 1'b0);
        wr(8'h20, 8'hdf);
        rd(8'h20, 8'hc7);
        wr(8'h20, 8'hff);
        rd(8'h20, 8'hc7);
        wr(8'h20, 8'hc1);
        rd(8'h20, 8'hc1);
        op(24'hff87ff, 1'b0, 1'b1);
        op(24'hff8800, 1'b0, 1'b0);
        op(24'hffc000, 1'b1, 1'b1);
        rd(8'h18, 8'h10);
        // special mode: free writes, sizes still frozen while ranges are active
        special_mode <= 1'b1;
        wr(8'h20, 8'hff, OKAY, 4'h0);
        rd(8'h20, 8'hc1);
        wr(8'h20, 8'hff);
        rd(8'h20, 8'he5);
        op(24'hffc000, 1'b1, 1'b0);
        wr(8'h20, 8'h7f);
        rd(8'h20, 8'h7f);
        op(24'hff9000, 1'b0, 1'b1);
        wr(8'h20, 8'h5b);
        rd(8'h20, 8'h5b);
        op(24'hffc000, 1'b0, 1'b0);
        op(24'hff8000, 1'b0, 1'b0);
        op(24'hffbfff, 1'b0, 1'b1);
        op(24'hffc000, 1'b1, 1'b1);
        special_mode <= 1'b0;
        wr(8'h20, 8'h7f);
        rd(8'h20, 8'h7f);
        wr(8'h20, 8'h5b);
        rd(8'h20, 8'h7f);
        // fault flags, write-one-to-clear, interrupt request
        wr(8'h24, 8'h01);
        rd(8'h24, 8'h01);
        flt(1'b0, 1'b1, 1'b0);
        rd(8'h1c, 8'h02);
        wr(8'h1c, 8'h00);
        rd(8'h1c, 8'h02);
        wr(8'h1c, 8'h02);
        rd(8'h1c, 8'h00);
        flt(1'b1, 1'b0, 1'b0);
        rd(8'h1c, 8'h01);
        chk_bit("irq", single_fault_irq, 1'b1);
        wr(8'h1c, 8'h00);
        rd(8'h1c, 8'h01);
        wr(8'h1c, 8'h01);
        rd(8'h1c, 8'h00);
        chk_bit("irq", single_fault_irq, 1'b0);
        flt(1'b0, 1'b0, 1'b1);
        rd(8'h1c, 8'h03);
        wr(8'h1c, 8'h03);
        rd(8'h1c, 8'h00);
        // ignore bit set: single reports dropped, double still kept
        wr(8'h24, 8'h03);
        flt(1'b1, 1'b0, 1'b1);
        rd(8'h1c, 8'h02);
        chk_bit("irq", single_fault_irq, 1'b0);
        wr(8'h1c, 8'h02);
        // unmapped word
        wr(8'h40, 8'h55, SLVERR);
        rd(8'h40, 8'h00, SLVERR);
        summarize();
    end

endmodule : fep_ctrl_bench

// ### fep_defs.svh
// register map, field positions, reset values and fixed addresses of the flash ecc/protection block
`ifndef FEP_DEFS_SVH
`define FEP_DEFS_SVH

// register indices; byte address is four times the index
`define FEP_IDX_FLASH_STATUS      6'h06
`define FEP_IDX_FLASH_ERROR_STAT  6'h07
`define FEP_IDX_PROGRAM_PROT      6'h08
`define FEP_IDX_FLASH_CONFIG      6'h09

// field positions
`define FEP_BIT_DOUBLE_FAULT      0+1
`define FEP_BIT_SINGLE_FAULT      0
`define FEP_BIT_PROT_VIOLATION    4
`define FEP_BIT_IRQ_ENABLE        0
`define FEP_BIT_IGNORE_SINGLE     1

// reset values
`define FEP_PROT_FULL             8'h7f
`define FEP_FLAGS_RESET           2'h0

// program flash window and range granules
`define FEP_PFLASH_BASE           24'hff8000
`define FEP_PFLASH_TOP            24'hffffff
`define FEP_NV_PROT_ADDR          24'hfffe0c
`define FEP_HIGH_UNIT             24'h000800
`define FEP_LOW_UNIT              24'h000400

// allowed scenario moves in normal mode, bit (from*8 + to)
`define FEP_MOVE_TABLE            64'hff5a3c18080c0a0f

// axi responses
`define FEP_RESP_OKAY             2'h0
`define FEP_RESP_SLVERR           2'h2

`endif

// ### fep_pkg.sv
// types of the flash ecc/protection block
package fep_pkg;

    typedef struct packed {
        logic       popen;   // protect_operation_enable
        logic       reserved_nonvolatile_bit;     // reserved_nonvolatile_bit
        logic       hdis;    // high_range_disable
        logic [1:0] hs;      // high_range_size
        logic       ldis;    // low_range_disable
        logic [1:0] ls;      // low_range_size
    } fep_prot_type;

    typedef struct packed {
        logic valid;         // array read finished this cycle
        logic single;        // one-bit error corrected
        logic double;        // two-bit error found
        logic busy_invalid;  // read of a block under command, data invalid
    } fep_rdfault_type;

    typedef struct packed {
        logic        valid;  // nonvolatile protection byte delivered
        logic        dfault; // double fault while reading it
        logic [7:0]  data;   // byte read from the fixed address
    } fep_nvload_type;

    typedef struct packed {
        logic        valid;  // program or erase requested
        logic        erase;  // block erase
        logic [23:0] addr;   // global target address
    } fep_opreq_type;

    typedef struct packed {
        logic         aw_ok;
        logic [5:0]   aw_idx;
        logic         w_ok;
        logic [7:0]   w_data;
        logic         w_lane;
        logic         awready;
        logic         wready;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         arready;
        logic         rvalid;
        logic [7:0]   rdata;
        logic [1:0]   rresp;
        logic         loaded;
        fep_prot_type prot;
        logic         stage_s;
        logic         stage_d;
        logic         single_fault_flag;
        logic         double_fault_flag;
        logic         viol;
        logic         irq_en;
        logic         ign_sf;
        logic         irq;
        logic         op_done;
        logic         op_reject;
    } fep_state_type;

endpackage : fep_pkg
